// ===== ind_sink_seq.sv
`timescale 1ns/1ps
module ind_sink_seq
  import ind_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  ind_timing_if.snk tim,
  input wire logic enable,
  input wire logic seq_enable,
  input wire logic [4:0] target_ma,
  output logic [4:0] level_q
);
  ind_state_e state_q, state_d;
  logic [4:0] level_d;
  logic [4:0] delta_q, delta_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [CNT_W-1:0] acc_q, acc_d;
  logic [CNT_W-1:0] acc_sum;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_d = state_q;
    level_d = level_q;
    delta_d = delta_q;
    cnt_d = cnt_q;
    acc_d = acc_q;
    acc_sum = acc_q + {{(CNT_W-5){1'b0}}, delta_q};
    case (state_q)
      ST_OFF: begin
        level_d = '0;
        if (enable) begin
          state_d = ST_RISE;
          delta_d = target_ma;
          cnt_d = '0;
          acc_d = '0;
        end
      end
      ST_RISE: begin
        if (!enable) begin
          state_d = ST_FALL;
          delta_d = level_q;
          cnt_d = '0;
          acc_d = '0;
        end else if (tim.rise_slots == '0 || cnt_q >= tim.rise_slots) begin
          level_d = target_ma;
          state_d = ST_HOLD;
          cnt_d = '0;
        end else if (tim.slot_tick) begin
          // error accumulator spreads delta steps evenly over the ramp
          cnt_d = cnt_q + 1'b1;
          acc_d = acc_sum;
          if (acc_sum >= tim.rise_slots) begin
            acc_d = acc_sum - tim.rise_slots;
            if (level_q < target_ma) level_d = level_q + 1'b1;
          end
        end
      end
      ST_HOLD: begin
        level_d = target_ma;
        if (!enable || (seq_enable && cnt_q >= tim.on_slots)) begin
          state_d = ST_FALL;
          delta_d = target_ma;
          cnt_d = '0;
          acc_d = '0;
        end else if (seq_enable && tim.slot_tick) begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      ST_FALL: begin
        if (tim.fall_slots == '0 || cnt_q >= tim.fall_slots) begin
          level_d = '0;
          cnt_d = '0;
          acc_d = '0;
          delta_d = target_ma;
          if (enable && seq_enable) state_d = ST_PAUSE;
          else if (enable) state_d = ST_RISE;
          else state_d = ST_OFF;
        end else if (tim.slot_tick) begin
          cnt_d = cnt_q + 1'b1;
          acc_d = acc_sum;
          if (acc_sum >= tim.fall_slots) begin
            acc_d = acc_sum - tim.fall_slots;
            if (level_q != '0) level_d = level_q - 1'b1;
          end
        end
      end
      ST_PAUSE: begin
        level_d = '0;
        if (!enable) begin
          state_d = ST_OFF;
        end else if (cnt_q >= tim.pause_slots) begin
          state_d = ST_RISE;
          delta_d = target_ma;
          cnt_d = '0;
          acc_d = '0;
        end else if (tim.slot_tick) begin
          cnt_d = cnt_q + 1'b1;
        end
      end
      default: begin
        state_d = ST_OFF;
        level_d = '0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_OFF;
      level_q <= '0;
      delta_q <= '0;
      cnt_q <= '0;
      acc_q <= '0;
    end else if (ce) begin
      state_q <= state_d;
      level_q <= level_d;
      delta_q <= delta_d;
      cnt_q <= cnt_d;
      acc_q <= acc_d;
    end
  end
endmodule : ind_sink_seq

// ===== ind_pkg.sv
// Operation
// - the third sink dimming output is high for (duty code + 1) of 32 slots of an 8 ms period.
// - duty code 0 gives 250 us high and 7.75 ms low in every period.
// - the top duty code keeps the dimming output high with no low slot.
// - the third sink on-time is its 5-bit code times 64 ms.
// - one 5-bit rise code sets the ramp-up time of all three sinks as code times 8 ms.
// - one 5-bit fall code sets the ramp-down time of all three sinks as code times 8 ms.
// - bits 6, 5 and 4 enable the first, second and third sink.
// - bits 2, 1 and 0 run the sequencer of the first, second and third sink.
// - current code 0..9 gives 2 mA to 20 mA in 2 mA steps and codes 10..15 give 20 mA.
// - reserved bits read as zero and ignore writes.
// - reset clears all duty, timing, ramp and enable registers to zero.
// - the pause phase length is a 7-bit code times 64 ms.
package ind_pkg;
  localparam logic [7:0] ADDR_DUTY = 8'h5d;
  localparam logic [7:0] ADDR_ON_TIME = 8'h5e;
  localparam logic [7:0] ADDR_RISE = 8'h5f;
  localparam logic [7:0] ADDR_FALL = 8'h60;
  localparam logic [7:0] ADDR_ENABLES = 8'h61;
  localparam int CODE_W = 5;
  localparam int SINK_EN_LSB = 4;
  localparam int SEQ_EN_LSB = 0;
  localparam int NUM_SINKS = 3;
  localparam logic [4:0] RESET_CODE = 5'h00;
  localparam logic [2:0] RESET_EN = 3'h0;
  localparam int CLK_PERIOD_NS = 40;
  localparam int SLOT_TIME_NS = 250000;
  localparam int SLOT_CYCLES = (SLOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIM_PERIOD_NS = 8000000;
  localparam int ON_UNIT_NS = 64000000;
  localparam int SLOTS_PER_PERIOD = DIM_PERIOD_NS / SLOT_TIME_NS;
  localparam int RAMP_SHIFT = $clog2(DIM_PERIOD_NS / SLOT_TIME_NS);
  localparam int ON_SHIFT = $clog2(ON_UNIT_NS / SLOT_TIME_NS);
  localparam int CNT_W = 16;
  localparam logic [3:0] MAX_CURRENT_CODE = 4'h9;
  localparam logic [4:0] CURRENT_STEP_MA = 5'h02;

  typedef enum logic [4:0] {
    ST_OFF = 5'b00001,
    ST_RISE = 5'b00010,
    ST_HOLD = 5'b00100,
    ST_FALL = 5'b01000,
    ST_PAUSE = 5'b10000
  } ind_state_e;

  // saturating table, codes above nine stay at the top current
  function automatic logic [4:0] ind_current_ma(input logic [3:0] code);
    logic [3:0] c;
    c = (code > MAX_CURRENT_CODE) ? MAX_CURRENT_CODE : code;
    return CURRENT_STEP_MA * ({1'b0, c} + 5'h01);
  endfunction : ind_current_ma
endpackage : ind_pkg

// ===== ind_timing_if.sv
`timescale 1ns/1ps
interface ind_timing_if;
  import ind_pkg::*;
  logic slot_tick;
  logic [CNT_W-1:0] rise_slots;
  logic [CNT_W-1:0] fall_slots;
  logic [CNT_W-1:0] on_slots;
  logic [CNT_W-1:0] pause_slots;
  modport src (output slot_tick, rise_slots, fall_slots, on_slots, pause_slots);
  modport snk (input slot_tick, rise_slots, fall_slots, on_slots, pause_slots);
endinterface : ind_timing_if

// ===== ind_dimming.sv
`timescale 1ns/1ps
module ind_dimming
  import ind_pkg::*;
#(
  parameter int SLOT_CYCLES_P = SLOT_CYCLES
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_q,
  input wire logic [11:0] sink_current_code,
  input wire logic [6:0] third_sink_phase1_length,
  output logic third_sink_dim_output,
  output logic [14:0] sink_current_ma
);
  localparam int PRE_W = $clog2(SLOT_CYCLES_P + 1);

  logic [4:0] duty_q, duty_d;
  logic [4:0] on_time_q, on_time_d;
  logic [4:0] rise_q, rise_d;
  logic [4:0] fall_q, fall_d;
  logic [2:0] sink_en_q, sink_en_d;
  logic [2:0] seq_en_q, seq_en_d;
  logic [7:0] rdata_d;
  logic [PRE_W-1:0] pre_q, pre_d;
  logic [4:0] slot_q, slot_d;
  logic dim_q, dim_d;
  logic tick;

  ind_timing_if tim ();

  ////////////////////////////////////////////////////////////////////////////
  // register file: only the code bits are stored, so reserved bits cannot hold writes
  always_comb begin
    duty_d = duty_q;
    on_time_d = on_time_q;
    rise_d = rise_q;
    fall_d = fall_q;
    sink_en_d = sink_en_q;
    seq_en_d = seq_en_q;
    if (reg_wr_en) begin
      case (reg_addr)
        ADDR_DUTY: duty_d = reg_wdata[CODE_W-1:0];
        ADDR_ON_TIME: on_time_d = reg_wdata[CODE_W-1:0];
        ADDR_RISE: rise_d = reg_wdata[CODE_W-1:0];
        ADDR_FALL: fall_d = reg_wdata[CODE_W-1:0];
        ADDR_ENABLES: begin
          sink_en_d = reg_wdata[SINK_EN_LSB +: NUM_SINKS];
          seq_en_d = reg_wdata[SEQ_EN_LSB +: NUM_SINKS];
        end
        default: ;
      endcase
    end
    rdata_d = reg_rdata_q;
    if (reg_rd_en) begin
      case (reg_addr)
        ADDR_DUTY: rdata_d = {3'h0, duty_q};
        ADDR_ON_TIME: rdata_d = {3'h0, on_time_q};
        ADDR_RISE: rdata_d = {3'h0, rise_q};
        ADDR_FALL: rdata_d = {3'h0, fall_q};
        ADDR_ENABLES: rdata_d = {1'b0, sink_en_q, 1'b0, seq_en_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      duty_q <= RESET_CODE;
      on_time_q <= RESET_CODE;
      rise_q <= RESET_CODE;
      fall_q <= RESET_CODE;
      sink_en_q <= RESET_EN;
      seq_en_q <= RESET_EN;
      reg_rdata_q <= 8'h00;
    end else if (ce) begin
      duty_q <= duty_d;
      on_time_q <= on_time_d;
      rise_q <= rise_d;
      fall_q <= fall_d;
      sink_en_q <= sink_en_d;
      seq_en_q <= seq_en_d;
      reg_rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // 250 us slot timebase, 32 slots make one 8 ms dimming period
  assign tick = (pre_q == PRE_W'(SLOT_CYCLES_P - 1));

  always_comb begin
    pre_d = tick ? '0 : pre_q + 1'b1;
    slot_d = tick ? slot_q + 1'b1 : slot_q;
    // a slot index never exceeds 31, so the top code gives no low slot
    dim_d = (slot_d <= duty_q);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= '0;
      slot_q <= '0;
      dim_q <= 1'b0;
    end else if (ce) begin
      pre_q <= pre_d;
      slot_q <= slot_d;
      dim_q <= dim_d;
    end
  end

  assign third_sink_dim_output = dim_q;

  ////////////////////////////////////////////////////////////////////////////
  assign tim.slot_tick = tick;
  assign tim.rise_slots = CNT_W'({rise_q, {RAMP_SHIFT{1'b0}}});
  assign tim.fall_slots = CNT_W'({fall_q, {RAMP_SHIFT{1'b0}}});
  assign tim.on_slots = CNT_W'({on_time_q, {ON_SHIFT{1'b0}}});
  assign tim.pause_slots = CNT_W'({third_sink_phase1_length, {ON_SHIFT{1'b0}}});

  // index 0 is the third sink, index 2 the first, matching the bit order of the enables
  for (genvar i = 0; i < NUM_SINKS; i++) begin : g_sink
    ind_sink_seq u_seq (
      .clk(clk),
      .rst_n(rst_n),
      .ce(ce),
      .tim(tim),
      .enable(sink_en_q[i]),
      .seq_enable(seq_en_q[i]),
      .target_ma(ind_current_ma(sink_current_code[4*i +: 4])),
      .level_q(sink_current_ma[5*i +: 5])
    );
  end
endmodule : ind_dimming

// ===== ind_dimming_checker.sv
`timescale 1ns/1ps
module ind_dimming_checker
  import ind_pkg::*;
#(
  parameter int SLOT_CYCLES_P = SLOT_CYCLES
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata_q,
  input wire logic [11:0] sink_current_code,
  input wire logic [6:0] third_sink_phase1_length,
  input wire logic third_sink_dim_output,
  input wire logic [14:0] sink_current_ma
);
  logic [19:0] hi_cnt_q, hi_cnt_d, lo_cnt_q, lo_cnt_d;
  logic [19:0] quiet_q, quiet_d;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////////////////////
  // run lengths of the dimming output, frozen with ce like the design
  always_comb begin
    hi_cnt_d = hi_cnt_q;
    lo_cnt_d = lo_cnt_q;
    quiet_d = quiet_q;
    if (ce) begin
      hi_cnt_d = third_sink_dim_output ? hi_cnt_q + 20'h00001 : 20'h00000;
      lo_cnt_d = third_sink_dim_output ? 20'h00000 : lo_cnt_q + 20'h00001;
      // cycles since reset or since the last duty write, saturating
      if (reg_wr_en && reg_addr == ADDR_DUTY) begin
        quiet_d = 20'h00000;
      end else if (quiet_q != 20'hfffff) begin
        quiet_d = quiet_q + 20'h00001;
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hi_cnt_q <= 20'h00000;
      lo_cnt_q <= 20'h00000;
      quiet_q <= 20'h00000;
    end else begin
      hi_cnt_q <= hi_cnt_d;
      lo_cnt_q <= lo_cnt_d;
      quiet_q <= quiet_d;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_wr_then_rd;
    ce && reg_wr_en && reg_addr inside {[ADDR_DUTY:ADDR_ENABLES]}
    ##1 ce && reg_rd_en && !reg_wr_en && $stable(reg_addr);
  endsequence
  AST_WR_RD_MASK: assert property (s_wr_then_rd |=> reg_rdata_q == ($past(reg_wdata, 2) &
    (($past(reg_addr) == ADDR_ENABLES) ? 8'h77 : 8'h1f))) else $error("masked readback wrong");
  AST_CODE_RESERVED_BIT: assert property (ce && reg_rd_en && reg_addr inside {[ADDR_DUTY:ADDR_FALL]}
    |=> reg_rdata_q[7:5] == 3'h0) else $error("code register reserved bits not zero");
  AST_EN_RESERVED_BIT: assert property (ce && reg_rd_en && reg_addr == ADDR_ENABLES
    |=> !reg_rdata_q[7] && !reg_rdata_q[3]) else $error("enable reserved bits not zero");
  AST_UNMAPPED: assert property (ce && reg_rd_en && !(reg_addr inside {[ADDR_DUTY:ADDR_ENABLES]})
    |=> reg_rdata_q == 8'h00) else $error("unmapped read not zero");
  AST_RDATA_HOLD: assert property (!(ce && reg_rd_en) |=> $stable(reg_rdata_q))
    else $error("read data moved without a read");
  AST_CUR_MAX: assert property (sink_current_ma[4:0] <= 5'h14 && sink_current_ma[9:5] <= 5'h14
    && sink_current_ma[14:10] <= 5'h14) else $error("sink current above top value");
  // the first run after reset and runs started by a duty write are not whole slots
  AST_DIM_HIGH_MIN: assert property ($fell(third_sink_dim_output)
    && quiet_q > hi_cnt_q + 20'h00001 |-> hi_cnt_q >= SLOT_CYCLES_P)
    else $error("dim high phase shorter than one slot");
  AST_DIM_LOW_MAX: assert property (lo_cnt_q <= 31 * SLOT_CYCLES_P)
    else $error("dim low phase longer than 31 slots");
endmodule : ind_dimming_checker
bind ind_dimming ind_dimming_checker #(.SLOT_CYCLES_P(SLOT_CYCLES_P)) chk_u (.clk(clk),
  .rst_n(rst_n), .ce(ce), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .sink_current_code(sink_current_code),
  .third_sink_phase1_length(third_sink_phase1_length),
  .third_sink_dim_output(third_sink_dim_output), .sink_current_ma(sink_current_ma));

// ===== tb.sv
`timescale 1ns/1ps
module tb;
  import ind_pkg::*;
  localparam int P = 4;
  logic clk = 1'b0;
  logic rst_n, ce, reg_wr_en, reg_rd_en, dim;
  logic [7:0] reg_addr, reg_wdata, reg_rdata_q;
  logic [11:0] codes;
  logic [6:0] pause_len;
  logic [14:0] cur;
  int num_errors = 0;
  int cmp_count = 0;
  int dl[4] = '{0, 5, 30, 31};
  always #20 clk = ~clk;
  ind_dimming #(.SLOT_CYCLES_P(P)) dut_u (.clk(clk), .rst_n(rst_n), .ce(ce),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata_q(reg_rdata_q), .sink_current_code(codes), .third_sink_phase1_length(pause_len),
    .third_sink_dim_output(dim), .sink_current_ma(cur));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [4:0] ma_of(input logic [3:0] c);
    return (c > 4'h9) ? 5'h14 : {c, 1'b0} + 5'h02;
  endfunction : ma_of
  task automatic chk_reg(input string n, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk_reg
  task automatic chk_cur(input string n, input logic [14:0] e);
    cmp_count++;
    if (cur !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, e, cur);
    end
  endtask : chk_cur
  task automatic chk_cnt(input string n, input int e, input int g);
    cmp_count++;
    if (g != e) begin
      num_errors++;
      $display("ERROR %s expected %0d seen %0d", n, e, g);
    end
  endtask : chk_cnt
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge clk);
    reg_wr_en = 1'b0;
  endtask : wr
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge clk);
    reg_rd_en = 1'b0;
    chk_reg("rdata", e, reg_rdata_q);
  endtask : rd_chk
  // write and read back on consecutive edges, the read sees the new value
  task automatic wr_rd_chk(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge clk);
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b1;
    @(negedge clk);
    reg_rd_en = 1'b0;
    chk_reg("rdata after write", e, reg_rdata_q);
  endtask : wr_rd_chk
  task automatic dim_cnt(input int d);
    int n;
    n = 0;
    wr(ADDR_DUTY, 8'(d));
    repeat (32 * P) @(negedge clk);
    repeat (32 * P) begin
      @(negedge clk);
      if (dim === 1'b1) n++;
    end
    chk_cnt("dim high cycles", (d + 1) * P, n);
  endtask : dim_cnt
  task automatic give_verdict;
    $display("checks %0d errors %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    {reg_wr_en, reg_rd_en} = 2'h0;
    {reg_addr, reg_wdata} = 16'h0000;
    codes = 12'h0c3;
    pause_len = 7'h01;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    chk_cur("currents after reset", 15'h0000);
    for (int i = 0; i < 5; i++) rd_chk(ADDR_DUTY + 8'(i), 8'h00);
    for (int i = 0; i < 5; i++) wr(ADDR_DUTY + 8'(i), 8'hff);
    for (int i = 0; i < 5; i++) rd_chk(ADDR_DUTY + 8'(i), (i == 4) ? 8'h77 : 8'h1f);
    wr(8'h62, 8'hff);
    rd_chk(8'h62, 8'h00);
    rd_chk(8'h5c, 8'h00);
    wr_rd_chk(ADDR_ON_TIME, 8'hea, 8'h0a);
    wr_rd_chk(ADDR_ENABLES, 8'h5a, 8'h52);
    for (int i = 0; i < 5; i++) wr(ADDR_DUTY + 8'(i), 8'h00);
    $display("test registers done");
    foreach (dl[i]) dim_cnt(dl[i]);
    $display("test dimming done");
    wr(ADDR_RISE, 8'h02);
    wr(ADDR_FALL, 8'h01);
    wr(ADDR_ENABLES, 8'h70);
    repeat (100) @(negedge clk);
    chk_cnt("mid rise", 1, int'(cur[4:0] > 5'h00 && cur[4:0] < 5'h08));
    repeat (200) @(negedge clk);
    chk_cur("after rise", {ma_of(4'h0), ma_of(4'hc), ma_of(4'h3)});
    wr(ADDR_ENABLES, 8'h00);
    repeat (60) @(negedge clk);
    chk_cnt("mid fall", 1, int'(cur[4:0] > 5'h00 && cur[4:0] < 5'h08));
    repeat (100) @(negedge clk);
    chk_cur("after fall", 15'h0000);
    $display("test ramps done");
    wr(ADDR_RISE, 8'h00);
    wr(ADDR_ON_TIME, 8'h01);
    wr(ADDR_ENABLES, 8'h11);
    repeat (500) @(negedge clk);
    chk_cur("in on-time", {10'h000, ma_of(4'h3)});
    repeat (800) @(negedge clk);
    chk_cur("in pause", 15'h0000);
    repeat (1000) @(negedge clk);
    chk_cur("next cycle", {10'h000, ma_of(4'h3)});
    $display("test sequencer done");
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    chk_cur("currents after second reset", 15'h0000);
    rd_chk(ADDR_DUTY, 8'h00);
    rd_chk(ADDR_ENABLES, 8'h00);
    $display("test reset done");
    give_verdict();
  end
endmodule : tb
